// File: hw/tscr_pkg.sv
// Constants for the switch control register block
package tscr_pkg;
    // Register width and reset value
    localparam int          REG_W         = 16;
    localparam logic [15:0] CTRL_RESET    = 16'h0000;
    // Field positions
    localparam int          BIT_MODE      = 9;
    localparam int          FILL_HI       = 8;
    localparam int          FILL_LO       = 5;
    localparam int          BIT_GO        = 4;
    localparam int          BIT_STANDBY   = 3;
    localparam int          BIT_EVAL      = 2;
    // Bits that store a value; all others read as zero
    localparam logic [15:0] CTRL_WMASK    = 16'h03FC;
    // Connection memory geometry
    localparam int          CM_AW         = 10;
    localparam int          CM_W          = 16;
    localparam logic [9:0]  CM_LAST       = 10'h3FF;
    // Block programming ends on the next frame pulse after this many are counted
    localparam logic [1:0]  PROG_FRAMES   = 2'h2;
    // Evaluation start idle-low frame count; no logic reads this constant
    localparam logic [1:0]  EVAL_REARM    = 2'h1;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FILL = 3'b010,
        ST_WAIT = 3'b100
    } tscr_state_t;
endpackage

// File: hw/tscr_edge.sv
// Rising change detector comparing a new bit against its stored value
`timescale 1ns/1ps
module tscr_edge (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic ce_i,
    input  wire logic wr_i,
    input  wire logic new_i,
    input  wire logic old_i,
    output logic      rise_o
);
    // One-cycle pulse when a write turns a stored zero into a one
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rise_o <= 1'b0;
        end else if (ce_i) begin
            rise_o <= wr_i & new_i & ~old_i;
        end
    end
endmodule

// File: hw/tscr_ctrl.sv
// Switch control register with block programming and evaluation start
// Overview of operation
// - A zero-to-one write of the go bit starts block programming.
// - Fill value is copied into connection memory bits 15 to 12.
// - Connection memory bits 11 to 0 are cleared during programming.
// - Block programming of the whole memory ends on the third frame pulse.
// - Device clears the go bit itself when programming finishes.
// - Writing zero to go or mode bit aborts programming.
// - A zero-to-one write of the evaluation start bit starts evaluation.
// - Evaluation stops when the completion flag rises.
// - Programming starts only when the mode bit is also set.
// - Pin low: standby bit gates drivers; pin high: drivers enabled.
`timescale 1ns/1ps
module tscr_ctrl (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        ce_i,
    input  wire logic        reg_sel_i,
    input  wire logic        reg_wr_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    input  wire logic        frame_i,
    input  wire logic        output_drive_enable_pin_i,
    input  wire logic        frame_eval_complete_i,
    output logic             cm_we_o,
    output logic      [9:0]  cm_addr_o,
    output logic      [15:0] cm_wdata_o,
    output logic             drivers_en_o,
    output logic             eval_run_o,
    output logic             prog_busy_o
);
    logic [15:0]          switch_control_reg;
    tscr_pkg::tscr_state_t state;
    logic                 wr;
    logic                 go_rise;
    logic                 eval_rise;
    logic [1:0]           frame_cnt;
    logic                 ode_s1;
    logic                 ode_s2;
    logic                 fr_s1;
    logic                 fr_s2;
    logic                 fr_d;
    logic                 cfe_s1;
    logic                 cfe_s2;
    logic                 cfe_d;
    logic                 frame_p;
    logic                 cfe_rise;
    logic                 prog_done;
    logic                 block_program_mode;
    logic                 block_program_go;
    logic                 output_standby;
    logic                 frame_eval_start;
    logic [3:0]           block_fill_value;

    assign wr                 = reg_sel_i & reg_wr_i;
    assign block_program_mode = switch_control_reg[tscr_pkg::BIT_MODE];
    assign block_program_go   = switch_control_reg[tscr_pkg::BIT_GO];
    assign output_standby     = switch_control_reg[tscr_pkg::BIT_STANDBY];
    assign frame_eval_start   = switch_control_reg[tscr_pkg::BIT_EVAL];
    assign block_fill_value   =
        switch_control_reg[tscr_pkg::FILL_HI:tscr_pkg::FILL_LO];
    assign frame_p            = fr_s2 & ~fr_d;
    assign cfe_rise           = cfe_s2 & ~cfe_d;
    assign prog_done = (state == tscr_pkg::ST_WAIT) &&
                       frame_p && (frame_cnt == tscr_pkg::PROG_FRAMES);

    // Two-stage synchronisers for pin and flag inputs
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ode_s1 <= 1'b0;
            ode_s2 <= 1'b0;
            fr_s1  <= 1'b0;
            fr_s2  <= 1'b0;
            fr_d   <= 1'b0;
            cfe_s1 <= 1'b0;
            cfe_s2 <= 1'b0;
            cfe_d  <= 1'b0;
        end else if (ce_i) begin
            ode_s1 <= output_drive_enable_pin_i;
            ode_s2 <= ode_s1;
            fr_s1  <= frame_i;
            fr_s2  <= fr_s1;
            fr_d   <= fr_s2;
            cfe_s1 <= frame_eval_complete_i;
            cfe_s2 <= cfe_s1;
            cfe_d  <= cfe_s2;
        end
    end

    // Edge detectors for go and evaluation start writes
    tscr_edge u_go_edge (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .ce_i     (ce_i),
        .wr_i     (wr & reg_wdata_i[tscr_pkg::BIT_MODE]),
        .new_i    (reg_wdata_i[tscr_pkg::BIT_GO]),
        .old_i    (block_program_go),
        .rise_o   (go_rise)
    );
    tscr_edge u_eval_edge (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .ce_i     (ce_i),
        .wr_i     (wr),
        .new_i    (reg_wdata_i[tscr_pkg::BIT_EVAL]),
        .old_i    (frame_eval_start),
        .rise_o   (eval_rise)
    );

    // Control register store; hardware clear of go on completion
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            switch_control_reg <= tscr_pkg::CTRL_RESET;
        end else if (ce_i) begin
            if (wr) begin
                switch_control_reg <= reg_wdata_i & tscr_pkg::CTRL_WMASK;
            end else if (prog_done) begin
                switch_control_reg[tscr_pkg::BIT_GO] <= 1'b0;
            end
        end
    end

    // Block programming sequencer
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state     <= tscr_pkg::ST_IDLE;
            frame_cnt <= 2'h0;
            cm_addr_o <= 10'h000;
            cm_we_o   <= 1'b0;
        end else if (ce_i) begin
            cm_we_o <= 1'b0;
            if (state != tscr_pkg::ST_IDLE &&
                (!block_program_go || !block_program_mode)) begin
                state <= tscr_pkg::ST_IDLE;
            end else begin
                case (state)
                    tscr_pkg::ST_IDLE: begin
                        if (go_rise) begin
                            state     <= tscr_pkg::ST_FILL;
                            cm_addr_o <= 10'h000;
                            frame_cnt <= 2'h0;
                        end
                    end
                    tscr_pkg::ST_FILL: begin
                        cm_we_o <= 1'b1;
                        if (cm_we_o) begin
                            if (cm_addr_o == tscr_pkg::CM_LAST) begin
                                state   <= tscr_pkg::ST_WAIT;
                                cm_we_o <= 1'b0;
                            end else begin
                                cm_addr_o <= cm_addr_o + 10'h001;
                            end
                        end
                        if (frame_p) begin
                            frame_cnt <= frame_cnt + 2'h1;
                        end
                    end
                    tscr_pkg::ST_WAIT: begin
                        if (frame_p) begin
                            if (frame_cnt == tscr_pkg::PROG_FRAMES) begin
                                state <= tscr_pkg::ST_IDLE;
                            end else begin
                                frame_cnt <= frame_cnt + 2'h1;
                            end
                        end
                    end
                    default: begin
                        state <= tscr_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Fill word: pattern on top, address part cleared
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cm_wdata_o <= 16'h0000;
        end else if (ce_i) begin
            cm_wdata_o <= {block_fill_value, 12'h000};
        end
    end

    // Evaluation run flag: set on start edge, cleared by completion
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            eval_run_o <= 1'b0;
        end else if (ce_i) begin
            if (eval_rise) begin
                eval_run_o <= 1'b1;
            end else if (cfe_rise) begin
                eval_run_o <= 1'b0;
            end
        end
    end

    // Driver enable, read data and busy flag
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            drivers_en_o <= 1'b0;
            reg_rdata_o  <= 16'h0000;
            prog_busy_o  <= 1'b0;
        end else if (ce_i) begin
            drivers_en_o <= ode_s2 | output_standby;
            reg_rdata_o  <= switch_control_reg;
            prog_busy_o  <= (state != tscr_pkg::ST_IDLE);
        end
    end

    // Assertions
    a_abort_stops: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && state != tscr_pkg::ST_IDLE && !block_program_go
        |=> state == tscr_pkg::ST_IDLE)
        else $error("programming not aborted");
    a_done_clears_go: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        ce_i && prog_done && !wr |=> !block_program_go)
        else $error("go bit not cleared");
    a_fill_word: assert property (@(posedge clk_i) disable iff (!resetn_i)
        cm_we_o |-> cm_wdata_o[11:0] == 12'h000)
        else $error("low bits not cleared");
    a_fill_pattern: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        cm_we_o && $stable(block_fill_value)
        |-> cm_wdata_o[15:12] == block_fill_value)
        else $error("pattern mismatch");
    a_start_needs_mode: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        ce_i && state == tscr_pkg::ST_IDLE && !go_rise
        |=> state == tscr_pkg::ST_IDLE)
        else $error("started without request");
    a_eval_start: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && eval_rise |=> eval_run_o)
        else $error("evaluation not started");
    a_eval_stop: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ce_i && cfe_rise && !eval_rise |=> !eval_run_o)
        else $error("evaluation not stopped");
    a_drv_pin_high: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        ce_i && ode_s2 |=> drivers_en_o)
        else $error("drivers off with pin high");
    a_reset_zero: assert property (@(posedge clk_i)
        !resetn_i |=> switch_control_reg == 16'h0000)
        else $error("reset value wrong");
    c_prog_done: cover property (@(posedge clk_i) prog_done);
    c_abort: cover property (@(posedge clk_i)
        state == tscr_pkg::ST_FILL && !block_program_go);
    c_eval: cover property (@(posedge clk_i) eval_run_o && cfe_rise);
endmodule

// File: tb/tscr_host.sv
// Host processor model issuing single-cycle register writes
`timescale 1ns/1ps
module tscr_host (
    input  wire logic        clk_i,
    output logic             reg_sel_o,
    output logic             reg_wr_o,
    output logic      [15:0] reg_wdata_o
);
    // Bus idle at time zero
    initial begin
        reg_sel_o   = 1'b0;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 16'h0000;
    end
    // One whole word per write, so go bit and fill value travel together
    task automatic write(input logic [15:0] d);
        @(negedge clk_i);
        reg_sel_o   = 1'b1;
        reg_wr_o    = 1'b1;
        reg_wdata_o = d;
        @(negedge clk_i);
        reg_sel_o   = 1'b0;
        reg_wr_o    = 1'b0;
        reg_wdata_o = ~d; // Stale data never looks valid
    endtask
endmodule

// File: tb/tsi_switch_control_register_tb.sv
// Self-checking bench for the switch control register
`timescale 1ns/1ps
module tsi_switch_control_register_tb;
    logic        clk_i    = 1'b0;
    logic        resetn_i = 1'b0;
    logic        frame_i  = 1'b0;
    logic        pin_i    = 1'b0;
    logic        done_i   = 1'b0;
    logic        ce       = 1'b1;
    logic [9:0]  hold_addr;
    logic        sel;
    logic        wr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] cm_wdata;
    logic [9:0]  cm_addr;
    logic        cm_we;
    logic        drv_en;
    logic        eval_run;
    logic        busy;
    logic [15:0] exp_cm   = 16'h0000;
    int          fails    = 0;
    int          num_checks = 0;
    int          wcnt     = 0;
    int          bad      = 0;
    int          snap     = 0;

    // 125 MHz clock
    always #4 clk_i = ~clk_i;

    tscr_host tscr_host_inst (
        .clk_i       (clk_i),
        .reg_sel_o   (sel),
        .reg_wr_o    (wr),
        .reg_wdata_o (wdata)
    );

    tscr_ctrl tscr_ctrl_inst (
        .clk_i                     (clk_i),
        .resetn_i                  (resetn_i),
        .ce_i                      (ce),
        .reg_sel_i                 (sel),
        .reg_wr_i                  (wr),
        .reg_wdata_i               (wdata),
        .reg_rdata_o               (rdata),
        .frame_i                   (frame_i),
        .output_drive_enable_pin_i (pin_i),
        .frame_eval_complete_i     (done_i),
        .cm_we_o                   (cm_we),
        .cm_addr_o                 (cm_addr),
        .cm_wdata_o                (cm_wdata),
        .drivers_en_o              (drv_en),
        .eval_run_o                (eval_run),
        .prog_busy_o               (busy)
    );

    // Tally writes taken at enabled edges; address steps from zero
    always @(posedge clk_i) begin
        if (ce === 1'b1 && cm_we === 1'b1) begin
            if (cm_wdata !== exp_cm || cm_addr !== wcnt[9:0])
                bad++;
            wcnt++;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic rd(input logic [15:0] exp);
        cyc(3);
        chk(rdata, exp);
    endtask

    task automatic frame_pulse();
        frame_i = 1'b1;
        cyc(4);
        frame_i = 1'b0;
        cyc(4);
    endtask

    task automatic give_verdict();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run of about 1200 cycles
    initial begin
        #200000;
        fails++;
        give_verdict();
    end

    // Main test sequence
    initial begin
        cyc(6);
        resetn_i = 1'b1;
        cyc(1);
        chk(rdata, 16'h0000);
        chk({15'h0000, drv_en}, 16'h0000);
        // Unused bits are written as zero, as the host must
        tscr_host_inst.write(16'h03E8);
        rd(16'h03E8);
        chk({15'h0000, drv_en}, 16'h0001);
        tscr_host_inst.write(16'h0000);
        pin_i = 1'b1;
        cyc(6);
        chk({15'h0000, drv_en}, 16'h0001);
        pin_i = 1'b0;
        cyc(6);
        chk({15'h0000, drv_en}, 16'h0000);
        // Go without mode must not start
        tscr_host_inst.write(16'h0150);
        cyc(4);
        chk({15'h0000, busy}, 16'h0000);
        tscr_host_inst.write(16'h0000);
        // Full block program with fill 0xA, frozen once mid-fill
        exp_cm = 16'hA000;
        tscr_host_inst.write(16'h0350);
        cyc(100);
        chk({15'h0000, busy}, 16'h0001);
        snap      = wcnt;
        hold_addr = cm_addr;
        ce        = 1'b0;
        cyc(10);
        chk(wcnt[15:0], snap[15:0]);
        chk({6'h00, cm_addr}, {6'h00, hold_addr});
        ce = 1'b1;
        for (int i = 0; i < 1100 && wcnt < 1024; i++)
            cyc(1);
        chk(wcnt[15:0], 16'h0400);
        chk(bad[15:0], 16'h0000);
        repeat (2) frame_pulse();
        chk(rdata, 16'h0350);
        frame_pulse();
        cyc(2);
        chk(rdata, 16'h0340);
        chk({15'h0000, busy}, 16'h0000);
        // Abort by clearing go, then by clearing mode
        wcnt   = 0;
        exp_cm = 16'h5000;
        tscr_host_inst.write(16'h02B0);
        cyc(20);
        chk({15'h0000, busy}, 16'h0001);
        tscr_host_inst.write(16'h02A0);
        cyc(4);
        chk({15'h0000, busy}, 16'h0000);
        snap = wcnt;
        cyc(10);
        chk(wcnt[15:0], snap[15:0]);
        // Restart fills from address zero again
        wcnt = 0;
        tscr_host_inst.write(16'h02B0);
        cyc(20);
        chk({15'h0000, busy}, 16'h0001);
        tscr_host_inst.write(16'h00B0);
        cyc(4);
        chk({15'h0000, busy}, 16'h0000);
        snap = wcnt;
        cyc(10);
        chk(wcnt[15:0], snap[15:0]);
        chk(bad[15:0], 16'h0000);
        // Frame evaluation start, completion and restart
        tscr_host_inst.write(16'h0004);
        cyc(3);
        chk({15'h0000, eval_run}, 16'h0001);
        done_i = 1'b1;
        cyc(8);
        chk({15'h0000, eval_run}, 16'h0000);
        done_i = 1'b0;
        tscr_host_inst.write(16'h0000);
        frame_pulse();
        tscr_host_inst.write(16'h0004);
        cyc(3);
        chk({15'h0000, eval_run}, 16'h0001);
        // Reset in mid-run clears register and evaluation flag
        resetn_i = 1'b0;
        cyc(2);
        resetn_i = 1'b1;
        cyc(1);
        chk(rdata, 16'h0000);
        chk({15'h0000, eval_run}, 16'h0000);
        give_verdict();
    end
endmodule
